/* rtl/sfr_reg_file.sv */
// Register file holding implemented special registers with reset map.
// Assumes synchronous strobes from the core; peripheral logic is outside.
`timescale 1ns/1ps
`default_nettype none
module sfr_reg_file
  import sfr_map_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       soft_reset,
  sfr_access_if.file      acc,
  input  wire logic [7:0] adc_result_in,
  output logic [7:0]      rdata,
  output logic            bank_sel,
  output logic [7:0]      ptr,
  output logic [4:0]      upper_pc,
  output logic [7:0]      pc_low,
  output logic            pc_load,
  output logic [4:0]      port_a_out,
  output logic [7:0]      port_b_out,
  output logic [4:0]      port_a_dir,
  output logic [7:0]      port_b_dir,
  output logic [7:0]      t0_cfg,
  output logic [7:0]      t2_ctl,
  output logic [7:0]      t2_per,
  output logic [7:0]      cp_ctl
);

  // ----------------------------------------------------------------
  // Decode helper
  // ----------------------------------------------------------------
  // Core registers answer at the same low address in both banks
  function automatic logic is_core(input logic [7:0] a, input logic [7:0] c);
    is_core = (a[6:0] == c[6:0]);
  endfunction : is_core

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] regs [0:255];   // Plain storage, masked per register
  logic [7:0] stat;           // Core status
  logic [7:0] wr_mask;        // Implemented bits at the address
  logic       wr_ok;          // Address implemented
  logic       core_hit;       // Shared core register

  always_comb begin
    wr_ok = 1'b1;
    wr_mask = R_ONES;
    core_hit = is_core(acc.addr, A_PC_LOW) || is_core(acc.addr, A_STAT) ||
               is_core(acc.addr, A_PTR) || is_core(acc.addr, A_UPC) ||
               is_core(acc.addr, A_ICTL);
    if (acc.is_ind && (acc.addr[6:0] == A_IND[6:0])) wr_ok = 1'b0;
    else if (core_hit) wr_mask = is_core(acc.addr, A_UPC) ? M_UPC : R_ONES;
    else if (acc.addr == A_T1L || acc.addr == A_T1H) wr_mask = R_ONES;
    else if (acc.addr == A_T1CTL) wr_mask = M_T1CTL;
    else if (acc.addr == A_T2CNT) wr_mask = R_ONES;
    else if (acc.addr == A_T2CTL) wr_mask = M_T2CTL;
    else if (acc.addr == A_CCL || acc.addr == A_CCH) wr_mask = R_ONES;
    else if (acc.addr == A_CPCTL || acc.addr == A_PWDB) wr_mask = R_ONES;
    else if (acc.addr == A_PWSD) wr_mask = M_PWSD;
    else if (acc.addr == A_ADCTL) wr_mask = R_ONES;
    else if (acc.addr == A_ADC_RES) wr_mask = R_ZERO;   // Readable, writes dropped
    else if (acc.addr == A_PORTA) wr_mask = M_PORTA;
    else if (acc.addr == A_PORTB) wr_mask = R_ONES;
    else if (acc.addr == A_T0CFG) wr_mask = R_ONES;
    else if (acc.addr == A_ADIR) wr_mask = M_ADIR;
    else if (acc.addr == A_BDIR) wr_mask = R_ONES;
    else if (acc.addr == A_PIE) wr_mask = M_PIE;
    else if (acc.addr == A_PWRF) wr_mask = M_PWRF;
    else if (acc.addr == A_T2PR) wr_mask = R_ONES;
    else if (acc.addr == A_ADCFG) wr_mask = M_ADCFG;
    else begin
      wr_ok = 1'b0;
      wr_mask = R_ZERO;
    end
  end

  // Canonical slot: core registers live at their bank-1 copy
  logic [7:0] slot;
  assign slot = core_hit ? {1'b1, acc.addr[6:0]} : acc.addr;

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) stat <= R_STAT;
    else if (soft_reset) stat <= stat & ~(8'h01 << STAT_BANK);
    else if (acc.wr && wr_ok && slot == A_STAT)
      stat <= (stat & ~M_STATW) | (acc.wdata & M_STATW);
  end

  // ----------------------------------------------------------------
  // General register writes
  // ----------------------------------------------------------------
  // Power-on values; other resets only reset the listed control regs
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 256; i++) regs[i] <= R_ZERO;
      regs[A_T0CFG] <= R_ONES;
      regs[A_T2PR]  <= R_ONES;
      regs[A_ADIR]  <= R_ADIR;
      regs[A_BDIR]  <= R_ONES;
      regs[A_PWRF]  <= R_PWRF;
    end else if (soft_reset) begin
      regs[A_ADIR]  <= R_ADIR;
      regs[A_BDIR]  <= R_ONES;
      regs[A_T0CFG] <= R_ONES;
      regs[A_T2PR]  <= R_ONES;
      regs[A_T2CTL] <= R_ZERO;
      regs[A_CPCTL] <= R_ZERO;
      regs[A_PWSD]  <= R_ZERO;
      regs[A_UPC]   <= R_ZERO;
      regs[A_PC_LOW] <= R_ZERO;
    end else if (acc.wr && wr_ok && slot != A_STAT) begin
      regs[slot] <= acc.wdata & wr_mask;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    if (!wr_ok) rdata = R_ZERO;
    else if (slot == A_STAT) rdata = stat;
    else if (slot == A_ADC_RES) rdata = adc_result_in;
    else rdata = regs[slot] & wr_mask;
  end

  // Writing the low PC byte pulses pc_load for one cycle, in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) pc_load <= 1'b0;
    else pc_load <= acc.wr && wr_ok && slot == A_PC_LOW;
  end

  assign bank_sel   = stat[STAT_BANK];
  assign ptr        = regs[A_PTR];
  assign upper_pc   = regs[A_UPC][UPCW-1:0];
  assign pc_low     = regs[A_PC_LOW];
  assign port_a_out = regs[A_PORTA][4:0];
  assign port_b_out = regs[A_PORTB];
  assign port_a_dir = regs[A_ADIR][4:0];
  assign port_b_dir = regs[A_BDIR];
  assign t0_cfg     = regs[A_T0CFG];
  assign t2_ctl     = regs[A_T2CTL];
  assign t2_per     = regs[A_T2PR];
  assign cp_ctl     = regs[A_CPCTL];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_unimpl_zero;
    @(posedge clk_sys) disable iff (!resetn)
      (acc.addr inside {[A_T2CTL + 8'h01 : A_CCL - 8'h01],
                        [A_PWSD + 8'h01 : A_ADC_RES - 8'h01],
                        [A_T2PR + 8'h01 : A_ADCFG - 8'h01]}) |-> rdata == R_ZERO;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimpl read nonzero");
  property p_shut_bit5;
    @(posedge clk_sys) disable iff (!resetn) regs[A_PWSD][5] == 1'b0;
  endproperty
  a_shut_bit5: assert property (p_shut_bit5) else $error("shutdown bit5 set");
  property p_soft_dirs;
    @(posedge clk_sys) disable iff (!resetn)
      soft_reset |=> port_a_dir == 5'h1F && port_b_dir == 8'hFF;
  endproperty
  a_soft_dirs: assert property (p_soft_dirs) else $error("dirs not inputs");
  property p_pc_load;
    @(posedge clk_sys) disable iff (!resetn)
      (acc.wr && wr_ok && slot == A_PC_LOW && !soft_reset) |=> pc_load;
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("pc load missing");
  property p_upc_width;
    @(posedge clk_sys) disable iff (!resetn) regs[A_UPC][7:5] == 3'b000;
  endproperty
  a_upc_width: assert property (p_upc_width) else $error("upper pc bits set");
  property p_core_shared;
    @(posedge clk_sys) disable iff (!resetn)
      (acc.wr && !soft_reset && !acc.is_ind && acc.addr == {1'b0, A_PTR[6:0]})
        |=> ptr == $past(acc.wdata);
  endproperty
  a_core_shared: assert property (p_core_shared) else $error("bank0 ptr miss");
  property p_port_latch;
    @(posedge clk_sys) disable iff (!resetn)
      (acc.wr && !soft_reset && acc.addr == A_PORTB) |=> port_b_out == $past(acc.wdata);
  endproperty
  a_port_latch: assert property (p_port_latch) else $error("port latch");
  property p_soft_t2;
    @(posedge clk_sys) disable iff (!resetn)
      soft_reset |=> t2_per == 8'hFF && t2_ctl == 8'h00 && cp_ctl == 8'h00;
  endproperty
  a_soft_t2: assert property (p_soft_t2) else $error("reset values");

endmodule : sfr_reg_file
`default_nettype wire

/* rtl/sfr_map_pkg.sv */
// Special function register map: addresses, field positions, reset values.
// Assumes an 8-bit core with two 128-byte banks selected by one status bit.
package sfr_map_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DW = 8;                         // Data width
  localparam int AW = 8;                         // Full file address width
  localparam int DIRW = 7;                       // Direct address field width
  localparam int UPCW = 5;                       // Upper PC width

  // ----------------------------------------------------------------
  // Addresses (bank 1 registers, incl. bank 1 copies of shared core registers)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_IND   = 8'h80;  // indirect_access_window
  localparam logic [7:0] A_T0CFG = 8'h81;  // timer0_prescale_config
  localparam logic [7:0] A_PC_LOW = 8'h82; // program_counter_low
  localparam logic [7:0] A_STAT  = 8'h83;  // core_status
  localparam logic [7:0] A_PTR   = 8'h84;  // indirect_pointer
  localparam logic [7:0] A_ADIR  = 8'h85;  // port_a_direction
  localparam logic [7:0] A_BDIR  = 8'h86;  // port_b_direction
  localparam logic [7:0] A_UPC   = 8'h8A;  // upper_pc_holding
  localparam logic [7:0] A_ICTL  = 8'h8B;  // interrupt_control
  localparam logic [7:0] A_PIE   = 8'h8C;  // peripheral_irq_enable
  localparam logic [7:0] A_PWRF  = 8'h8E;  // power_reset_flags
  localparam logic [7:0] A_T2PR  = 8'h92;  // timer2_period
  localparam logic [7:0] A_ADCFG = 8'h9F;  // adc_pin_config
  // Bank 0 peripherals
  localparam logic [7:0] A_T1L   = 8'h0E;
  localparam logic [7:0] A_T1H   = 8'h0F;
  localparam logic [7:0] A_T1CTL = 8'h10;
  localparam logic [7:0] A_T2CNT = 8'h11;
  localparam logic [7:0] A_T2CTL = 8'h12;
  localparam logic [7:0] A_CCL   = 8'h15;
  localparam logic [7:0] A_CCH   = 8'h16;
  localparam logic [7:0] A_CPCTL = 8'h17;
  localparam logic [7:0] A_PWDB  = 8'h18;
  localparam logic [7:0] A_PWSD  = 8'h19;
  localparam logic [7:0] A_ADC_RES = 8'h1E;  // Read-only conversion result
  localparam logic [7:0] A_ADCTL = 8'h1F;
  localparam logic [7:0] A_PORTA = 8'h05;
  localparam logic [7:0] A_PORTB = 8'h06;
  localparam logic [6:0] CORE_MASK = 7'h7F;  // Low address field

  // ----------------------------------------------------------------
  // Implemented-bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] M_T1CTL = 8'h3F;
  localparam logic [7:0] M_T2CTL = 8'h7F;
  localparam logic [7:0] M_PWSD  = 8'hDF;   // Bit 5 absent
  localparam logic [7:0] M_ADIR  = 8'h1F;
  localparam logic [7:0] M_PORTA = 8'h1F;
  localparam logic [7:0] M_UPC   = 8'h1F;
  localparam logic [7:0] M_PIE   = 8'h47;
  localparam logic [7:0] M_PWRF  = 8'h03;
  localparam logic [7:0] M_ADCFG = 8'h07;
  localparam logic [7:0] M_STATW = 8'hE7;   // Timeout/powerdown not writable
  localparam logic [7:0] R_ZERO  = 8'h00;
  localparam logic [7:0] R_ONES  = 8'hFF;
  localparam logic [7:0] R_ADIR  = 8'h1F;
  localparam logic [7:0] R_STAT  = 8'h18;   // Timeout and powerdown set
  localparam logic [7:0] R_PWRF  = 8'h03;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAT_BANK = 5;                  // bank_select_bit
  localparam int STAT_TO   = 4;
  localparam int STAT_PD   = 3;

endpackage : sfr_map_pkg

/* rtl/sfr_access_if.sv */
// Decoded access from the address front end to the register file.
// Assumes one clock; the core presents a single access per cycle.
`timescale 1ns/1ps
`default_nettype none
interface sfr_access_if;
  logic [7:0] addr;       // Resolved full address
  logic       is_ind;     // Went through the indirect window
  logic       rd;         // Read strobe
  logic       wr;         // Write strobe
  logic [7:0] wdata;      // Write data
  modport front (output addr, output is_ind, output rd, output wr, output wdata);
  modport file  (input addr, input is_ind, input rd, input wr, input wdata);
endinterface : sfr_access_if
`default_nettype wire

/* rtl/sfr_addr_resolve.sv */
// Address front end: bank concatenation and indirect redirection.
// Assumes the core's direct field and pointer are stable during access.
`timescale 1ns/1ps
`default_nettype none
module sfr_addr_resolve
  import sfr_map_pkg::*;
(
  input  wire logic [6:0] dir_addr,
  input  wire logic       bank_sel,
  input  wire logic [7:0] ptr,
  input  wire logic       rd_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  sfr_access_if.front     acc
);
  // ----------------------------------------------------------------
  // Resolution
  // ----------------------------------------------------------------
  logic [7:0] direct_full;  // Bank bit plus direct field
  always_comb begin
    direct_full = {bank_sel, dir_addr};
    // Window address in either bank goes through the pointer
    if ((direct_full[6:0] & CORE_MASK) == A_IND[6:0]) begin
      acc.addr   = ptr;
      acc.is_ind = 1'b1;
    end else begin
      acc.addr   = direct_full;
      acc.is_ind = 1'b0;
    end
    acc.rd    = rd_in;
    acc.wr    = wr_in;
    acc.wdata = wdata_in;
  end
endmodule : sfr_addr_resolve
`default_nettype wire

/* verification/core_model.sv */
// Core model: issues single-cycle direct reads and writes.
// Assumes bank_sel is fed back from the register file.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic       clk_sys,
  input  wire logic       bank_sel,
  output logic [6:0]      dir_addr,
  output logic            rd_in,
  output logic            wr_in,
  output logic [7:0]      wdata_in
);
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // Change after a falling edge, hold over the next rising edge
  task automatic put(input logic [7:0] a, input logic r, input logic [7:0] d);
    @(negedge clk_sys);
    if (a[7] !== bank_sel) begin
      // Flip the bank through the shared status register
      {dir_addr, rd_in, wr_in} = {7'h03, 2'h1};
      wdata_in = {2'h0, a[7], 5'h00};  // Reserved bits kept clear
      @(posedge clk_sys);
      @(negedge clk_sys);
    end
    {dir_addr, rd_in, wr_in} = {a[6:0], r, ~r};
    wdata_in = d;
    @(posedge clk_sys);
  endtask : put

  // Stale address and data are inverted so a lost strobe shows
  task automatic idle();
    @(negedge clk_sys);
    {rd_in, wr_in} = 2'h0;
    dir_addr = ~dir_addr;
    wdata_in = ~wdata_in;
  endtask : idle

  initial begin
    {dir_addr, rd_in, wr_in, wdata_in} = 17'h0_0000;
  end
endmodule : core_model
`default_nettype wire

/* verification/testbench.sv */
// Testbench for the register map: reset, decode, indirect, masks.
// Assumes the core model above and the design package.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sfr_map_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic       soft_reset = 1'b0;
  logic [7:0] adc_val = 8'h00;
  logic [7:0] rdata, ptr, pc_low, port_b_out, port_b_dir, t0_cfg;
  logic [7:0] t2_ctl, t2_per, cp_ctl, wdata_in, d;
  logic [4:0] upper_pc, port_a_out, port_a_dir;
  logic [6:0] dir_addr;
  logic       bank_sel, pc_load, rd_in, wr_in;
  int         miscompares = 0;
  int         checks = 0;
  logic [7:0] exp_q[$];     // Expected read data, oldest first
  string      nam_q[$];
  localparam logic [15:0] RST_T[16] = '{16'h1000, 16'h1100, 16'h1200,
    16'h1700, 16'h1800, 16'h1900, 16'h1F00, 16'h81FF, 16'h8200, 16'h851F,
    16'h86FF, 16'h8A00, 16'h8C00, 16'h8E03, 16'h92FF, 16'h9F00};
  localparam logic [15:0] MSK_T[13] = '{16'h103F, 16'h127F, 16'h17FF,
    16'h18FF, 16'h19DF, 16'h81FF, 16'h851F, 16'h86FF, 16'h8A1F, 16'h8C47,
    16'h92FF, 16'h8E03, 16'h9F07};
  localparam logic [7:0] GAP_T[9] = '{8'h13, 8'h14, 8'h1A, 8'h1D, 8'h93,
    8'h97, 8'h9E, 8'h07, 8'h8D};

  always #2.5 clk_sys = ~clk_sys;

  sfr_access_if acc_if();
  core_model core_model_i(.clk_sys, .bank_sel, .dir_addr, .rd_in, .wr_in, .wdata_in);
  sfr_addr_resolve sfr_addr_resolve_i(.dir_addr, .bank_sel, .ptr, .rd_in, .wr_in,
    .wdata_in, .acc(acc_if));
  sfr_reg_file sfr_reg_file_i(.clk_sys, .resetn, .soft_reset, .acc(acc_if),
    .adc_result_in(adc_val), .rdata, .bank_sel, .ptr, .upper_pc, .pc_low, .pc_load,
    .port_a_out, .port_b_out, .port_a_dir, .port_b_dir, .t0_cfg, .t2_ctl,
    .t2_per, .cp_ctl);

  // ----------------------------------------------------------------
  // Compare, verdict
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // Read data is taken at the edge that samples the strobe
  always @(posedge clk_sys) begin
    if (acc_if.rd === 1'b1) begin
      check(nam_q.pop_front(), rdata, exp_q.pop_front());
    end
  end

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    exp_q.push_back(e);
    nam_q.push_back(n);
    core_model_i.put(a, 1'b1, 8'h00);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    core_model_i.put(a, 1'b0, v);
  endtask : wr

  // Hang guard, far beyond the hundred or so cycles needed
  initial begin
    #20000;
    miscompares++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(43232));
    adc_val = $urandom;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    rd(8'h03, R_STAT, "status_rst");
    rd(8'h1E, adc_val, "adc_res");
    foreach (RST_T[i]) rd(RST_T[i][15:8], RST_T[i][7:0], "rst_val");
    // Unused slots read zero whatever was written
    foreach (GAP_T[i]) begin
      wr(GAP_T[i], $urandom);
      rd(GAP_T[i], 8'h00, "gap");
    end
    // Absent bits drop, incl. shutdown bit 5
    foreach (MSK_T[i]) begin
      d = $urandom;
      wr(MSK_T[i][15:8], d);
      rd(MSK_T[i][15:8], d & MSK_T[i][7:0], "masked");
    end
    // Shared core slots and the indirect window
    d = $urandom;
    wr(8'h84, 8'h92);
    rd(8'h04, 8'h92, "ptr_shared");
    wr(8'h00, d);
    rd(8'h92, d, "ind_wr");
    rd(8'h80, d, "ind_rd");
    wr(8'h84, 8'h80);
    rd(8'h00, 8'h00, "ind_self");
    // Low byte write pulses pc_load; upper_pc follows the holding register
    wr(8'h0A, 8'hF5);
    rd(8'h8A, 8'h15, "upc_shared");
    wr(8'h02, 8'h34);
    core_model_i.idle();
    check("pc_load", pc_load, 8'h01);
    check("upper_pc", upper_pc, 8'h15);
    check("pc_low", pc_low, 8'h34);
    @(negedge clk_sys);
    check("pc_load_end", pc_load, 8'h00);
    // Same low address, different bank
    wr(8'h05, d);
    wr(8'h06, ~d);
    wr(8'h85, 8'h00);
    rd(8'h05, d & M_PORTA, "port_a");
    core_model_i.idle();
    check("port_a_out", port_a_out, d & M_PORTA);
    check("port_b_out", port_b_out, ~d);
    check("port_a_dir", port_a_dir, 8'h00);
    // Pin or watchdog reset differs from power-up
    wr(8'h86, 8'h00);
    wr(8'h81, 8'h00);
    core_model_i.idle();
    soft_reset = 1'b1;
    @(negedge clk_sys);
    soft_reset = 1'b0;
    check("port_a_dir_sr", port_a_dir, R_ADIR);
    check("port_b_dir_sr", port_b_dir, R_ONES);
    check("t0_cfg_sr", t0_cfg, R_ONES);
    check("t2_per_sr", t2_per, R_ONES);
    check("t2_ctl_sr", t2_ctl, R_ZERO);
    check("cp_ctl_sr", cp_ctl, R_ZERO);
    check("upper_pc_sr", upper_pc, R_ZERO);
    check("pc_low_sr", pc_low, R_ZERO);
    check("ptr_kept", ptr, 8'h80);
    check("port_a_kept", port_a_out, d & M_PORTA);
    check("bank_sr", bank_sel, 8'h00);
    // Power-on reset mid-run clears what the pin reset kept
    resetn = 1'b0;
    @(negedge clk_sys);
    resetn = 1'b1;
    check("ptr_por", ptr, 8'h00);
    check("port_a_por", port_a_out, 8'h00);
    check("t2_per_por", t2_per, R_ONES);
    check("port_a_dir_por", port_a_dir, R_ADIR);
    rd(8'h03, R_STAT, "status_por");
    core_model_i.idle();
    repeat (2) @(negedge clk_sys);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
